/* core/sdl_lock_gate.sv */
// Drive security lock gate: register slave, command gate and lock state.
//
// The Avalon-MM register port and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module sdl_lock_gate #(
  parameter logic [31:0] NATIVE_MAX = 32'h00FF_FFFF,
  // Factory master password; the value is arbitrary.
  parameter logic [31:0] MASTER_DEFAULT = 32'h5EC0_0001
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [sdl_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic erase_o,
  output logic media_enable_o
);
  logic [31:0] wmask, wdata;
  logic bus_req, bus_go, cmd_go, hrst;
  logic [7:0] op, feat;
  logic msel, lvl;
  logic user_match, master_match, sel_match;
  logic load_user, load_master, fail_ev, acc;
  logic [31:0] rd_mux;
  logic [15:0] w128;
  logic next_wait;
  logic [31:0] next_rdata;
  sdl_pkg::sdl_mode_t mode, next_mode;
  logic user_en, next_user_en;
  logic lvl_max, next_lvl_max;
  logic [15:0] rev, next_rev;
  logic [2:0] fail_cnt, next_fail_cnt;
  logic expired, next_expired;
  logic [31:0] arg, next_arg;
  logic [31:0] pw, next_pw;
  logic [31:0] max_addr, next_max_addr;
  logic [sdl_pkg::CMD_W-1:0] last_cmd, next_last_cmd;
  logic ok, next_ok;
  logic bad, next_bad;
  logic next_erase, next_media;

  function automatic logic is_media(input logic [7:0] o, input logic [7:0] f);
    logic m;
    m = 1'b0;
    for (int i = 0; i < sdl_pkg::MEDIA_N; i++) begin
      if (o == sdl_pkg::MEDIA_OPS[i]) begin
        m = 1'b1;
      end
    end
    if (o == sdl_pkg::OP_DEV_CFG) begin
      m = (f == sdl_pkg::FEAT_CFG_RESTORE) || (f == sdl_pkg::FEAT_CFG_SET);
    end
    return m;
  endfunction

  assign wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                  {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  assign wdata = avs_writedata_i & wmask;
  assign bus_req = avs_read_i || avs_write_i;
  // Writes land only on the edge where waitrequest is seen low.
  assign bus_go = bus_req && !avs_waitrequest_o;
  assign cmd_go = bus_go && avs_write_i && (avs_address_i == sdl_pkg::OFF_CMD);
  assign hrst = bus_go && avs_write_i && (avs_address_i == sdl_pkg::OFF_CTRL)
                && wdata[sdl_pkg::CTRL_HRST_BIT];
  assign op = wdata[sdl_pkg::CMD_OP_LSB +: 8];
  assign feat = wdata[sdl_pkg::CMD_FEAT_LSB +: 8];
  assign msel = wdata[sdl_pkg::CMD_MSEL_BIT];
  assign lvl = wdata[sdl_pkg::CMD_LVL_BIT];
  assign sel_match = msel ? master_match : user_match;

  // The default master password lives here until a master set-password replaces it.
  sdl_pw_slot #(.W(sdl_pkg::PW_W), .INIT(MASTER_DEFAULT)) u_master (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .load_i(load_master),
    .pw_i(pw),
    .match_o(master_match)
  );

  // No user password after power-on, so the drive starts unlocked.
  sdl_pw_slot #(.W(sdl_pkg::PW_W), .INIT('0)) u_user (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .load_i(load_user),
    .pw_i(pw),
    .match_o(user_match)
  );

  always_comb begin
    w128 = '0;
    w128[sdl_pkg::W128_SUPP_BIT] = 1'b1;
    w128[sdl_pkg::W128_EN_BIT] = user_en;
    w128[sdl_pkg::W128_LOCK_BIT] = (mode == sdl_pkg::MODE_LOCKED);
    w128[sdl_pkg::W128_FROZ_BIT] = (mode == sdl_pkg::MODE_FROZEN);
    w128[sdl_pkg::W128_ATTEMPT_LIMIT_EXPIRED_FLAG_BIT] = expired;
    w128[sdl_pkg::W128_LVL_BIT] = lvl_max;
    case (avs_address_i)
      sdl_pkg::OFF_CMD: rd_mux = {{(32 - sdl_pkg::CMD_W){1'b0}}, last_cmd};
      sdl_pkg::OFF_ARG: rd_mux = arg;
      sdl_pkg::OFF_STATUS: rd_mux = {22'h0, bad, ok, fail_cnt, expired, lvl_max,
                                     user_en, mode};
      sdl_pkg::OFF_ID92: rd_mux = {16'h0000, rev};
      sdl_pkg::OFF_ID128: rd_mux = {16'h0000, w128};
      sdl_pkg::OFF_CAP: rd_mux = max_addr;
      default: rd_mux = 32'h0000_0000;
    endcase
    next_wait = avs_waitrequest_o ? !bus_req : 1'b1;
    next_rdata = (bus_req && avs_waitrequest_o && avs_read_i) ? rd_mux : avs_readdata_o;
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
    end else begin
      avs_waitrequest_o <= next_wait;
      avs_readdata_o <= next_rdata;
    end
  end

  always_comb begin
    next_mode = mode;
    next_user_en = user_en;
    next_lvl_max = lvl_max;
    next_rev = rev;
    next_fail_cnt = fail_cnt;
    next_expired = expired;
    next_arg = arg;
    next_pw = pw;
    next_max_addr = max_addr;
    next_last_cmd = last_cmd;
    next_ok = ok;
    next_bad = bad;
    next_erase = 1'b0;
    load_user = 1'b0;
    load_master = 1'b0;
    fail_ev = 1'b0;
    acc = 1'b1;
    if (hrst) begin
      // A stored user password relocks the drive, even out of frozen state.
      if (user_en) begin
        next_mode = sdl_pkg::MODE_LOCKED;
      end
      next_fail_cnt = 3'h0;
      next_expired = 1'b0;
    end
    if (bus_go && avs_write_i && (avs_address_i == sdl_pkg::OFF_ARG)) begin
      next_arg = (arg & ~wmask) | wdata;
    end
    if (bus_go && avs_write_i && (avs_address_i == sdl_pkg::OFF_PWD)) begin
      next_pw = (pw & ~wmask) | wdata;
    end
    if (cmd_go) begin
      next_last_cmd = wdata[sdl_pkg::CMD_W-1:0];
      case (op)
        sdl_pkg::OP_SET_PW: begin
          if (mode != sdl_pkg::MODE_UNLOCKED) begin
            acc = 1'b0;
          end else if (msel) begin
            // Reserved codes are refused so identify never shows them.
            if (arg[15:0] >= sdl_pkg::REV_MIN && arg[15:0] <= sdl_pkg::REV_MAX) begin
              load_master = 1'b1;
              next_rev = arg[15:0];
            end else begin
              acc = 1'b0;
            end
          end else begin
            load_user = 1'b1;
            next_user_en = 1'b1;
            next_lvl_max = lvl;
          end
        end
        sdl_pkg::OP_UNLOCK, sdl_pkg::OP_ERASE_UNIT: begin
          if (mode == sdl_pkg::MODE_FROZEN || expired) begin
            acc = 1'b0;
          end else if (!sel_match) begin
            acc = 1'b0;
            fail_ev = 1'b1;
          end else if (op == sdl_pkg::OP_ERASE_UNIT) begin
            next_erase = 1'b1;
            next_mode = sdl_pkg::MODE_UNLOCKED;
            next_user_en = 1'b0;
          end else if (msel && lvl_max) begin
            acc = 1'b0;
          end else begin
            next_mode = sdl_pkg::MODE_UNLOCKED;
          end
        end
        sdl_pkg::OP_ERASE_PREP: begin
          acc = 1'b1;
        end
        sdl_pkg::OP_FREEZE: begin
          if (mode == sdl_pkg::MODE_LOCKED) begin
            acc = 1'b0;
          end else begin
            next_mode = sdl_pkg::MODE_FROZEN;
          end
        end
        sdl_pkg::OP_DIS_PW: begin
          if (mode != sdl_pkg::MODE_UNLOCKED) begin
            acc = 1'b0;
          end else if (!sel_match) begin
            acc = 1'b0;
            fail_ev = 1'b1;
          end else if (msel && lvl_max) begin
            acc = 1'b0;
          end else begin
            next_user_en = 1'b0;
          end
        end
        sdl_pkg::OP_NATIVE_MAX: begin
          next_arg = NATIVE_MAX;
        end
        sdl_pkg::OP_SET_MAX, sdl_pkg::OP_SET_MAX_EXT: begin
          // Subfunctions 01h..04h are taken in every mode; their modes are not kept.
          if (op == sdl_pkg::OP_SET_MAX && feat >= sdl_pkg::SUB_MAX_PW
              && feat <= sdl_pkg::SUB_MAX_FREEZE) begin
            acc = 1'b1;
          end else if (mode == sdl_pkg::MODE_LOCKED) begin
            acc = 1'b0;
          end else if (op == sdl_pkg::OP_SET_MAX && feat != sdl_pkg::SUB_MAX_ADDR) begin
            acc = 1'b0;
          end else begin
            next_max_addr = (arg > NATIVE_MAX) ? NATIVE_MAX : arg;
          end
        end
        default: begin
          acc = !(mode == sdl_pkg::MODE_LOCKED && is_media(op, feat));
        end
      endcase
      if (fail_ev && fail_cnt != sdl_pkg::FAIL_LIMIT) begin
        next_fail_cnt = fail_cnt + 3'h1;
        if (fail_cnt + 3'h1 == sdl_pkg::FAIL_LIMIT) begin
          next_expired = 1'b1;
        end
      end
      next_ok = acc;
      next_bad = !acc;
    end
    next_media = (next_mode != sdl_pkg::MODE_LOCKED);
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      mode <= sdl_pkg::MODE_UNLOCKED;
      user_en <= 1'b0;
      lvl_max <= 1'b0;
      rev <= sdl_pkg::REV_DEFAULT;
      fail_cnt <= 3'h0;
      expired <= 1'b0;
      arg <= 32'h0000_0000;
      pw <= 32'h0000_0000;
      max_addr <= NATIVE_MAX;
      last_cmd <= '0;
      ok <= 1'b0;
      bad <= 1'b0;
      erase_o <= 1'b0;
      media_enable_o <= 1'b1;
    end else begin
      mode <= next_mode;
      user_en <= next_user_en;
      lvl_max <= next_lvl_max;
      rev <= next_rev;
      fail_cnt <= next_fail_cnt;
      expired <= next_expired;
      arg <= next_arg;
      pw <= next_pw;
      max_addr <= next_max_addr;
      last_cmd <= next_last_cmd;
      ok <= next_ok;
      bad <= next_bad;
      erase_o <= next_erase;
      media_enable_o <= next_media;
    end
  end

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  locked_media_a: assert property (cmd_go && mode == sdl_pkg::MODE_LOCKED && op == 8'hC8
    |=> bad && !ok && mode == sdl_pkg::MODE_LOCKED)
    else $error("Locked drive took a media command.");
  frozen_sec_a: assert property (cmd_go && mode == sdl_pkg::MODE_FROZEN
    && (op == 8'hF1 || op == 8'hF2 || op == 8'hF4 || op == 8'hF6) |=> bad && !erase_o)
    else $error("Frozen drive took a security command.");
  frozen_stays_a: assert property (mode == sdl_pkg::MODE_FROZEN && !(hrst && user_en)
    |=> mode == sdl_pkg::MODE_FROZEN)
    else $error("Frozen state was left.");
  attempt_limit_expired_flag_set_a: assert property (fail_ev && fail_cnt == 3'h4
    |=> expired && fail_cnt == 3'h5)
    else $error("Fifth mismatch did not attempt_limit_expired_flag.");
  expired_abort_a: assert property (cmd_go && expired && (op == 8'hF2 || op == 8'hF4)
    |=> bad && $stable(mode))
    else $error("Expired drive took unlock or erase.");
  master_nolock_a: assert property (cmd_go && op == 8'hF1 && msel
    |=> $stable(user_en))
    else $error("Master password changed the lock function.");
  hrst_lock_a: assert property (hrst && user_en
    |=> mode == sdl_pkg::MODE_LOCKED && fail_cnt == 3'h0 && !expired && !media_enable_o)
    else $error("Hard reset did not relock.");
  erase_state_a: assert property (erase_o
    |-> mode == sdl_pkg::MODE_UNLOCKED && !user_en && media_enable_o && ok)
    else $error("Erase left the drive locked.");
  rev_range_a: assert property (rev != 16'h0000 && rev != 16'hFFFF)
    else $error("Reserved revision code stored.");
  bus_answer_a: assert property (bus_req && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("Bus answer missing.");
endmodule
`default_nettype wire

/* core/sdl_pkg.sv */
// Shared constants for the drive security lock gate.
package sdl_pkg;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned PW_W = 32;
  // Register byte offsets.
  localparam logic [4:0] OFF_CMD = 5'h00;
  localparam logic [4:0] OFF_PWD = 5'h04;
  localparam logic [4:0] OFF_ARG = 5'h08;
  localparam logic [4:0] OFF_STATUS = 5'h0C;
  localparam logic [4:0] OFF_ID92 = 5'h10;
  localparam logic [4:0] OFF_ID128 = 5'h14;
  localparam logic [4:0] OFF_CAP = 5'h18;
  localparam logic [4:0] OFF_CTRL = 5'h1C;
  // Command and control register fields.
  localparam int unsigned CMD_OP_LSB = 0;
  localparam int unsigned CMD_FEAT_LSB = 8;
  localparam int unsigned CMD_MSEL_BIT = 16;
  localparam int unsigned CMD_LVL_BIT = 17;
  localparam int unsigned CMD_W = 18;
  localparam int unsigned CTRL_HRST_BIT = 0;
  // Identify word 128 bit positions.
  localparam int unsigned W128_SUPP_BIT = 0;
  localparam int unsigned W128_EN_BIT = 1;
  localparam int unsigned W128_LOCK_BIT = 2;
  localparam int unsigned W128_FROZ_BIT = 3;
  localparam int unsigned W128_ATTEMPT_LIMIT_EXPIRED_FLAG_BIT = 4;
  localparam int unsigned W128_LVL_BIT = 8;
  // Master revision code limits and default, and the attempt limit.
  localparam logic [15:0] REV_DEFAULT = 16'hFFFE;
  localparam logic [15:0] REV_MIN = 16'h0001;
  localparam logic [15:0] REV_MAX = 16'hFFFE;
  localparam logic [2:0] FAIL_LIMIT = 3'h5;
  // Security and protected-area opcodes.
  localparam logic [7:0] OP_SET_PW = 8'hF1;
  localparam logic [7:0] OP_UNLOCK = 8'hF2;
  localparam logic [7:0] OP_ERASE_PREP = 8'hF3;
  localparam logic [7:0] OP_ERASE_UNIT = 8'hF4;
  localparam logic [7:0] OP_FREEZE = 8'hF5;
  localparam logic [7:0] OP_DIS_PW = 8'hF6;
  localparam logic [7:0] OP_NATIVE_MAX = 8'hF8;
  localparam logic [7:0] OP_SET_MAX = 8'hF9;
  localparam logic [7:0] OP_SET_MAX_EXT = 8'h37;
  localparam logic [7:0] OP_DEV_CFG = 8'hB1;
  localparam logic [7:0] FEAT_CFG_RESTORE = 8'hC0;
  localparam logic [7:0] FEAT_CFG_SET = 8'hC3;
  localparam logic [7:0] SUB_MAX_ADDR = 8'h00;
  localparam logic [7:0] SUB_MAX_PW = 8'h01;
  localparam logic [7:0] SUB_MAX_FREEZE = 8'h04;
  // Reads, writes, verify, format and flush that a locked drive refuses.
  localparam int unsigned MEDIA_N = 20;
  localparam logic [7:0] MEDIA_OPS [0:MEDIA_N-1] = '{
    8'h20, 8'h24, 8'h22, 8'hC8, 8'h25, 8'hC4, 8'h29, 8'h42, 8'h30, 8'h34,
    8'h32, 8'hCA, 8'h35, 8'hC5, 8'h39, 8'h3C, 8'h50, 8'hF7, 8'hE7, 8'hEA};
  typedef enum logic [1:0] {
    MODE_LOCKED = 2'h0,
    MODE_UNLOCKED = 2'h1,
    MODE_FROZEN = 2'h3
  } sdl_mode_t;
endpackage

/* core/sdl_pw_slot.sv */
// One stored password with its comparator.
`timescale 1ns/10ps
`default_nettype none
module sdl_pw_slot #(
  parameter int unsigned W = 32,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic [W-1:0] pw_i,
  output logic match_o
);
  logic [W-1:0] pw;
  logic [W-1:0] next_pw;

  always_comb begin
    next_pw = load_i ? pw_i : pw;
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      pw <= INIT;
    end else begin
      pw <= next_pw;
    end
  end

  assign match_o = (pw == pw_i);
endmodule
`default_nettype wire

/* tb/sdl_host_model.sv */
// Host-side Avalon-MM master model that issues drive commands to the lock gate.
`timescale 1ns/10ps
`default_nettype none
module sdl_host_model (
  input wire logic clock_i,
  input wire logic avs_waitrequest_i,
  input wire logic [31:0] avs_readdata_i,
  output logic [sdl_pkg::ADDR_W-1:0] avs_address_o,
  output logic avs_read_o,
  output logic avs_write_o,
  output logic [31:0] avs_writedata_o,
  output logic [3:0] avs_byteenable_o
);
  initial begin
    avs_address_o = '0;
    avs_read_o = 1'b0;
    avs_write_o = 1'b0;
    avs_writedata_o = 32'h0;
    avs_byteenable_o = 4'hF;
  end

  // The request stays fixed until waitrequest is seen low or 64 cycles pass, after which the cycle is dropped as failed.
  task automatic bus_cycle(input logic [4:0] addr, input logic wr, input logic [31:0] data,
                           output logic [31:0] rdata, output bit ok);
    int n;
    ok = 1'b0;
    rdata = 32'h0;
    @(posedge clock_i);
    avs_address_o <= addr;
    avs_writedata_o <= wr ? data : 32'h0;
    avs_write_o <= wr;
    avs_read_o <= !wr;
    for (n = 0; n < 64 && !ok; n++) begin
      @(posedge clock_i);
      if (avs_waitrequest_i === 1'b0) begin
        ok = 1'b1;
        rdata = avs_readdata_i;
      end
    end
    avs_write_o <= 1'b0;
    avs_read_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* tb/drive_security_lock_gate_tb_top.sv */
// Self-checking testbench for the drive security lock gate.
`timescale 1ns/10ps
`default_nettype none
module drive_security_lock_gate_tb_top;
  // Factory master password; the value is arbitrary.
  localparam logic [31:0] MDEF = 32'h5EC0_0001;
  localparam logic [31:0] NMAX = 32'h0012_3456;
  localparam logic [31:0] U1 = 32'hA1A1_0001;
  localparam logic [31:0] U2 = 32'hB2B2_0002;
  localparam logic [31:0] M1 = 32'hC3C3_0003;
  localparam logic [31:0] BAD = 32'hDEAD_0BAD;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [4:0] addr;
  logic rd_s, wr_s, wait_s, erase_s, media_s;
  logic [31:0] wdata, rdata;
  logic [3:0] be;
  int err_total = 0;
  int check_count = 0;
  int erase_cnt = 0;
  logic [7:0] ok_ops [0:5] = '{8'hEC, 8'hE5, 8'h90, 8'hE4, 8'h70, 8'hB0};

  always #12.5 clock_i = ~clock_i;
  always @(posedge clock_i) if (erase_s === 1'b1) erase_cnt <= erase_cnt + 1;

  sdl_lock_gate #(.NATIVE_MAX(NMAX), .MASTER_DEFAULT(MDEF)) i_sdl_lock_gate (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .avs_address_i(addr), .avs_read_i(rd_s),
    .avs_write_i(wr_s), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_s), .erase_o(erase_s),
    .media_enable_o(media_s));
  sdl_host_model i_sdl_host_model (
    .clock_i(clock_i), .avs_waitrequest_i(wait_s), .avs_readdata_i(rdata),
    .avs_address_o(addr), .avs_read_o(rd_s), .avs_write_o(wr_s),
    .avs_writedata_o(wdata), .avs_byteenable_o(be));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q);
    bit ok;
    i_sdl_host_model.bus_cycle(a, w, d, q, ok);
    if (!ok) begin
      err_total++;
      stop_test();
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask

  task automatic field(input logic [4:0] a, input int lsb, input int w,
                       input logic [31:0] exp, input string nm);
    logic [31:0] q;
    logic [31:0] m;
    bus(a, 1'b0, 32'h0, q);
    m = (w == 32) ? 32'hFFFF_FFFF : ((32'h1 << w) - 32'h1);
    check(nm, (q >> lsb) & m, exp);
  endtask

  task automatic mode_is(input logic [1:0] m);
    field(sdl_pkg::OFF_STATUS, 0, 2, {30'h0, m}, "mode");
  endtask

  task automatic hard_rst();
    wr(sdl_pkg::OFF_CTRL, 32'h0000_0001);
  endtask

  // The outcome is judged from the accepted and aborted flags of the status word.
  task automatic cmd(input logic [7:0] op, input logic [7:0] ft, input int ms,
                     input int lv, input logic [31:0] pw, input int acc);
    wr(sdl_pkg::OFF_PWD, pw);
    wr(sdl_pkg::OFF_CMD, {14'h0, lv[0], ms[0], ft, op});
    field(sdl_pkg::OFF_STATUS, 8, 2, acc ? 32'h1 : 32'h2, $sformatf("accept op %h", op));
  endtask

  task automatic s_reset();
    mode_is(sdl_pkg::MODE_UNLOCKED);
    field(sdl_pkg::OFF_ID92, 0, 16, 32'h0000_FFFE, "rev default");
    field(sdl_pkg::OFF_CAP, 0, 32, NMAX, "cap default");
    field(sdl_pkg::OFF_PWD, 0, 32, 32'h0, "pwd read");
    check("media en", {31'h0, media_s}, 32'h1);
    for (int i = 0; i < sdl_pkg::MEDIA_N; i++) cmd(sdl_pkg::MEDIA_OPS[i], 8'h00, 0, 0, 0, 1);
  endtask

  task automatic s_default_master();
    cmd(sdl_pkg::OP_SET_PW, 8'h00, 0, 0, U1, 1);
    field(sdl_pkg::OFF_STATUS, 2, 1, 32'h1, "lock en");
    check("media before reset", {31'h0, media_s}, 32'h1);
    hard_rst();
    mode_is(sdl_pkg::MODE_LOCKED);
    check("media locked", {31'h0, media_s}, 32'h0);
    for (int i = 0; i < sdl_pkg::MEDIA_N; i++) cmd(sdl_pkg::MEDIA_OPS[i], 8'h00, 0, 0, 0, 0);
    cmd(sdl_pkg::OP_DEV_CFG, sdl_pkg::FEAT_CFG_RESTORE, 0, 0, 0, 0);
    cmd(sdl_pkg::OP_DEV_CFG, sdl_pkg::FEAT_CFG_SET, 0, 0, 0, 0);
    cmd(sdl_pkg::OP_SET_MAX, sdl_pkg::SUB_MAX_ADDR, 0, 0, 0, 0);
    cmd(sdl_pkg::OP_SET_MAX_EXT, 8'h00, 0, 0, 0, 0);
    for (int i = 1; i <= 4; i++) cmd(sdl_pkg::OP_SET_MAX, 8'(i), 0, 0, 0, 1);
    for (int i = 0; i < 6; i++) cmd(ok_ops[i], 8'h00, 0, 0, 0, 1);
    cmd(sdl_pkg::OP_SET_PW, 8'h00, 0, 0, 0, 0);
    cmd(sdl_pkg::OP_DIS_PW, 8'h00, 0, 0, 0, 0);
    cmd(sdl_pkg::OP_FREEZE, 8'h00, 0, 0, 0, 0);
    cmd(sdl_pkg::OP_ERASE_PREP, 8'h00, 0, 0, 0, 1);
    cmd(sdl_pkg::OP_UNLOCK, 8'h00, 1, 0, MDEF, 1);
    mode_is(sdl_pkg::MODE_UNLOCKED);
    check("media unlocked", {31'h0, media_s}, 32'h1);
    cmd(sdl_pkg::OP_DIS_PW, 8'h00, 0, 0, U1, 1);
  endtask

  task automatic s_master();
    wr(sdl_pkg::OFF_ARG, 32'h0000_1234);
    cmd(sdl_pkg::OP_SET_PW, 8'h00, 1, 0, M1, 1);
    field(sdl_pkg::OFF_ID92, 0, 16, 32'h0000_1234, "rev stored");
    field(sdl_pkg::OFF_STATUS, 2, 1, 32'h0, "lock en master");
    hard_rst();
    mode_is(sdl_pkg::MODE_UNLOCKED);
    wr(sdl_pkg::OFF_ARG, 32'h0000_0000);
    cmd(sdl_pkg::OP_SET_PW, 8'h00, 1, 0, M1, 0);
    wr(sdl_pkg::OFF_ARG, 32'h0000_FFFF);
    cmd(sdl_pkg::OP_SET_PW, 8'h00, 1, 0, M1, 0);
    field(sdl_pkg::OFF_ID92, 0, 16, 32'h0000_1234, "rev kept");
  endtask

  task automatic s_attempts();
    int e0;
    cmd(sdl_pkg::OP_SET_PW, 8'h00, 0, 0, U2, 1);
    hard_rst();
    mode_is(sdl_pkg::MODE_LOCKED);
    cmd(sdl_pkg::OP_UNLOCK, 8'h00, 0, 0, BAD, 0);
    field(sdl_pkg::OFF_STATUS, 5, 3, 32'h1, "count user");
    cmd(sdl_pkg::OP_UNLOCK, 8'h00, 1, 0, BAD, 0);
    field(sdl_pkg::OFF_STATUS, 5, 3, 32'h2, "count master");
    field(sdl_pkg::OFF_ID128, 4, 1, 32'h0, "expired early");
    repeat (3) cmd(sdl_pkg::OP_UNLOCK, 8'h00, 0, 0, BAD, 0);
    field(sdl_pkg::OFF_ID128, 4, 1, 32'h1, "expired");
    e0 = erase_cnt;
    cmd(sdl_pkg::OP_UNLOCK, 8'h00, 0, 0, U2, 0);
    cmd(sdl_pkg::OP_ERASE_UNIT, 8'h00, 1, 0, M1, 0);
    check("no erase", erase_cnt - e0, 32'h0);
    hard_rst();
    field(sdl_pkg::OFF_ID128, 4, 1, 32'h0, "expired cleared");
    field(sdl_pkg::OFF_STATUS, 5, 3, 32'h0, "count cleared");
    cmd(sdl_pkg::OP_UNLOCK, 8'h00, 1, 0, M1, 1);
    mode_is(sdl_pkg::MODE_UNLOCKED);
  endtask

  task automatic s_max();
    int e0;
    cmd(sdl_pkg::OP_SET_PW, 8'h00, 0, 1, U1, 1);
    field(sdl_pkg::OFF_ID128, 8, 1, 32'h1, "level max");
    hard_rst();
    cmd(sdl_pkg::OP_UNLOCK, 8'h00, 1, 0, M1, 0);
    mode_is(sdl_pkg::MODE_LOCKED);
    e0 = erase_cnt;
    cmd(sdl_pkg::OP_ERASE_UNIT, 8'h00, 1, 0, M1, 1);
    check("erase pulse", erase_cnt - e0, 32'h1);
    mode_is(sdl_pkg::MODE_UNLOCKED);
    field(sdl_pkg::OFF_STATUS, 2, 1, 32'h0, "lock en erased");
    hard_rst();
    mode_is(sdl_pkg::MODE_UNLOCKED);
  endtask

  // A power-on reset in mid-run must clear the count and flag and lose the user password.
  task automatic s_por();
    cmd(sdl_pkg::OP_SET_PW, 8'h00, 0, 0, U1, 1);
    hard_rst();
    repeat (5) cmd(sdl_pkg::OP_UNLOCK, 8'h00, 0, 0, BAD, 0);
    field(sdl_pkg::OFF_ID128, 4, 1, 32'h1, "expired pre por");
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    field(sdl_pkg::OFF_ID128, 4, 1, 32'h0, "expired por");
    field(sdl_pkg::OFF_STATUS, 5, 3, 32'h0, "count por");
    mode_is(sdl_pkg::MODE_UNLOCKED);
    field(sdl_pkg::OFF_STATUS, 2, 1, 32'h0, "lock en por");
    check("media por", {31'h0, media_s}, 32'h1);
  endtask

  task automatic s_frozen();
    int e0;
    cmd(sdl_pkg::OP_NATIVE_MAX, 8'h00, 0, 0, 0, 1);
    field(sdl_pkg::OFF_ARG, 0, 32, NMAX, "native max");
    wr(sdl_pkg::OFF_ARG, 32'h0000_1000);
    cmd(sdl_pkg::OP_SET_MAX, sdl_pkg::SUB_MAX_ADDR, 0, 0, 0, 1);
    field(sdl_pkg::OFF_CAP, 0, 32, 32'h0000_1000, "cap set");
    cmd(sdl_pkg::OP_FREEZE, 8'h00, 0, 0, 0, 1);
    mode_is(sdl_pkg::MODE_FROZEN);
    e0 = erase_cnt;
    cmd(sdl_pkg::OP_SET_PW, 8'h00, 0, 0, U2, 0);
    cmd(sdl_pkg::OP_DIS_PW, 8'h00, 1, 0, M1, 0);
    cmd(sdl_pkg::OP_ERASE_UNIT, 8'h00, 1, 0, M1, 0);
    cmd(sdl_pkg::OP_UNLOCK, 8'h00, 1, 0, M1, 0);
    check("no erase frozen", erase_cnt - e0, 32'h0);
    cmd(8'h20, 8'h00, 0, 0, 0, 1);
    cmd(8'h30, 8'h00, 0, 0, 0, 1);
    hard_rst();
    mode_is(sdl_pkg::MODE_FROZEN);
  endtask

  initial begin
    repeat (20) @(posedge clock_i);
    rst_n_i <= 1'b1;
    s_reset();
    s_default_master();
    s_master();
    s_attempts();
    s_max();
    s_por();
    s_frozen();
    stop_test();
  end
endmodule
`default_nettype wire
